// ==== hw/eocs_pkg.sv ====
// Purpose: shared types of the external output control port
// Assumes: one clock domain
// Notes:   types only; numbers live in eocs_regs.svh
package eocs_pkg;

  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } eocs_wb_req_t;

  typedef struct packed {
    logic voltage_regulation_mode;
    logic current_regulation_mode;
    logic overvoltage_protect;
    logic overcurrent_protect;
    logic overtemp_protect;
  } eocs_plant_t;

  typedef struct packed {
    logic const_voltage_flag;
    logic const_current_flag;
    logic output_on_flag;
    logic alarm_flag;
    logic option_flag;
  } eocs_status_t;

  typedef enum logic [2:0] {
    EOCS_OFF     = 3'b001,
    EOCS_ON      = 3'b010,
    EOCS_INHIBIT = 3'b100
  } eocs_state_t;

endpackage : eocs_pkg

// ==== hw/eocs_regs.svh ====
// Purpose: register map and timing constants of the external output control port
// Assumes: 32-bit classic Wishbone, byte addresses, word aligned
// Notes:   offsets are byte addresses; reserved bits read zero
`ifndef EOCS_REGS_SVH
`define EOCS_REGS_SVH

`define EOCS_ADDR_W        8
`define EOCS_OFS_CTRL      8'h00
`define EOCS_OFS_CMD       8'h04
`define EOCS_OFS_STATUS    8'h08
`define EOCS_OFS_IRQ_STAT  8'h0C
`define EOCS_OFS_IRQ_MASK  8'h10

// control register fields
`define EOCS_CTRL_POL_BIT  0
`define EOCS_CTRL_OPT_BIT  1
`define EOCS_CTRL_RESET    32'h0000_0001

// command register fields (write-one pulses)
`define EOCS_CMD_ON_BIT    0
`define EOCS_CMD_OFF_BIT   1

// status register fields
`define EOCS_ST_OUT_ON     0
`define EOCS_ST_CV         1
`define EOCS_ST_CC         2
`define EOCS_ST_ALARM      3
`define EOCS_ST_INHIBIT    4
`define EOCS_ST_TRIP       5
`define EOCS_ST_OPT        6

// event bits
`define EOCS_EV_W          4
`define EOCS_EV_ON         0
`define EOCS_EV_OFF        1
`define EOCS_EV_ALARM      2
`define EOCS_EV_TRIP       3
`define EOCS_MASK_RESET    4'h0

// debounce time for contact inputs
`define EOCS_DEB_US        2
`define EOCS_CLK_MHZ       125
`define EOCS_DEB_CYC       (`EOCS_DEB_US * `EOCS_CLK_MHZ)

`endif

// ==== hw/eocs_sync_deb.sv ====
// Purpose: two-flop synchroniser plus debounce filter for one contact input
// Assumes: input asynchronous to clk_sys
// Notes:   output changes only after the input is stable for DEB_CYC cycles
`include "eocs_regs.svh"

module eocs_sync_deb #(
  parameter int          DEB_CYC = `EOCS_DEB_CYC,
  parameter logic        INIT    = 1'b1
) (
  // clock and reset
  input  wire logic clk_sys,
  input  wire logic reset,
  // pin and filtered level
  input  wire logic pin_in,
  output logic      level
);

  localparam int CW = $clog2(DEB_CYC + 1);

  logic          meta;
  logic          sync;
  logic [CW-1:0] cnt;

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      meta <= INIT;
      sync <= INIT;
    end else begin
      meta <= pin_in;
      sync <= meta;
    end
  end

  // bounce restarts the count, so a chattering contact never reaches the output
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      cnt   <= '0;
      level <= INIT;
    end else if (sync == level) begin
      cnt <= '0;
    end else if (cnt == CW'(DEB_CYC - 1)) begin
      cnt   <= '0;
      level <= sync;
    end else begin
      cnt <= cnt + CW'(1);
    end
  end

endmodule : eocs_sync_deb

// ==== hw/eocs_top.sv ====
// Purpose: external output on/off, shutdown trip and status outputs of a power supply
// Assumes: one clock clk_sys at 125 MHz, contact pins asynchronous
// Notes:   status outputs are active high drive levels for the photocoupler stages
// Notes on behaviour
// - with high polarity a low-to-high edge on the external input turns the output on and a low level holds it off.
// - a polarity setting inverts the sense of the external on/off input.
// - while the external input holds the output off, panel key and remote on requests are ignored.
// - a low shutdown input or closed shutdown contact trips the power breaker.
// - the voltage and current mode flags follow the regulation mode.
// - the output-on flag follows the main output state.
// - the alarm flag is active while any protection condition is present.
// - the option output changes only by a port-output command over the bus.
`include "eocs_regs.svh"

module eocs_top #(
  parameter int DEB_CYC = `EOCS_DEB_CYC
) (
  // clock and reset
  input  wire logic                    clk_sys,
  input  wire logic                    reset,
  // wishbone slave
  input  wire eocs_pkg::eocs_wb_req_t  wb_req,
  output logic                         wb_ack,
  output logic [31:0]                  wb_dat_o,
  output logic                         irq,
  // contact pins
  input  wire logic                    ext_onoff_pin,
  input  wire logic                    shutdown_n_pin,
  // panel key, one-cycle pulse from local logic
  input  wire logic                    panel_key_press,
  // plant state from the regulator
  input  wire eocs_pkg::eocs_plant_t   plant,
  // outputs
  output logic                         output_enable,
  output logic                         breaker_trip,
  output eocs_pkg::eocs_status_t       status
);

  eocs_pkg::eocs_state_t state;
  eocs_pkg::eocs_state_t next_state;

  logic                  onoff_lvl;
  logic                  shut_lvl;
  logic                  onoff_prev;
  logic                  ext_active;
  logic                  ext_rise;
  logic                  pol_high;
  logic                  opt_level;
  logic                  cmd_on;
  logic                  cmd_off;
  logic                  alarm_now;
  logic                  alarm_prev;
  logic                  trip_prev;
  logic [31:0]           status_word;
  logic [`EOCS_EV_W-1:0] events;

  // contacts idle high through the pull-ups
  eocs_sync_deb #(
    .DEB_CYC (DEB_CYC),
    .INIT    (1'b1)
  ) u_deb_onoff (
    .clk_sys (clk_sys),
    .reset   (reset),
    .pin_in  (ext_onoff_pin),
    .level   (onoff_lvl)
  );

  eocs_sync_deb #(
    .DEB_CYC (DEB_CYC),
    .INIT    (1'b1)
  ) u_deb_shut (
    .clk_sys (clk_sys),
    .reset   (reset),
    .pin_in  (shutdown_n_pin),
    .level   (shut_lvl)
  );

  eocs_wb_regs u_regs (
    .clk_sys     (clk_sys),
    .reset       (reset),
    .wb_req      (wb_req),
    .wb_ack      (wb_ack),
    .wb_dat_o    (wb_dat_o),
    .status_word (status_word),
    .events      (events),
    .pol_high    (pol_high),
    .opt_level   (opt_level),
    .cmd_on      (cmd_on),
    .cmd_off     (cmd_off),
    .irq         (irq)
  );

  // polarity folds the pin into one active-high sense
  assign ext_active = pol_high ? onoff_lvl : !onoff_lvl;

  // edge taken on the polarity-folded level, so a polarity write can itself
  // look like an edge; software should change polarity while output is off
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      onoff_prev <= 1'b1;
    end else begin
      onoff_prev <= ext_active;
    end
  end

  assign ext_rise = ext_active && !onoff_prev;

  always_comb begin
    next_state = state;
    case (state)
      eocs_pkg::EOCS_OFF: begin
        if (!ext_active) begin
          next_state = eocs_pkg::EOCS_INHIBIT;
        end else if (panel_key_press || cmd_on) begin
          next_state = eocs_pkg::EOCS_ON;
        end
      end
      eocs_pkg::EOCS_ON: begin
        if (!ext_active) begin
          next_state = eocs_pkg::EOCS_INHIBIT;
        end else if (panel_key_press || cmd_off) begin
          next_state = eocs_pkg::EOCS_OFF;
        end
      end
      eocs_pkg::EOCS_INHIBIT: begin
        // key and remote on requests are dropped here
        if (ext_rise) begin
          next_state = eocs_pkg::EOCS_ON;
        end
      end
      default: next_state = eocs_pkg::EOCS_OFF;
    endcase
    if (breaker_trip) begin
      next_state = eocs_pkg::EOCS_OFF;
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      state <= eocs_pkg::EOCS_OFF;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      output_enable <= 1'b0;
    end else begin
      output_enable <= (next_state == eocs_pkg::EOCS_ON);
    end
  end

  // breaker follows the debounced contact; re-power needs it high again
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      breaker_trip <= 1'b0;
    end else begin
      breaker_trip <= !shut_lvl;
    end
  end

  assign alarm_now = plant.overvoltage_protect || plant.overcurrent_protect
                     || plant.overtemp_protect;

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      status <= '0;
    end else begin
      status.const_voltage_flag <= plant.voltage_regulation_mode;
      status.const_current_flag <= plant.current_regulation_mode;
      status.output_on_flag     <= output_enable;
      status.alarm_flag         <= alarm_now;
      status.option_flag        <= opt_level;
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      alarm_prev <= 1'b0;
      trip_prev  <= 1'b0;
    end else begin
      alarm_prev <= alarm_now;
      trip_prev  <= breaker_trip;
    end
  end

  logic out_prev;
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      out_prev <= 1'b0;
    end else begin
      out_prev <= output_enable;
    end
  end

  always_comb begin
    events                 = '0;
    events[`EOCS_EV_ON]    = output_enable && !out_prev;
    events[`EOCS_EV_OFF]   = !output_enable && out_prev;
    events[`EOCS_EV_ALARM] = alarm_now && !alarm_prev;
    events[`EOCS_EV_TRIP]  = breaker_trip && !trip_prev;
  end

  always_comb begin
    status_word                   = 32'h0000_0000;
    status_word[`EOCS_ST_OUT_ON]  = output_enable;
    status_word[`EOCS_ST_CV]      = plant.voltage_regulation_mode;
    status_word[`EOCS_ST_CC]      = plant.current_regulation_mode;
    status_word[`EOCS_ST_ALARM]   = alarm_now;
    status_word[`EOCS_ST_INHIBIT] = !ext_active;
    status_word[`EOCS_ST_TRIP]    = breaker_trip;
    status_word[`EOCS_ST_OPT]     = opt_level;
  end

endmodule : eocs_top

// ==== hw/eocs_wb_regs.sv ====
// Purpose: classic Wishbone slave holding control, mask and interrupt status
// Assumes: 32-bit data, byte addresses, one register per aligned word
// Notes:   ack one cycle after the request is seen, one cycle wide
`include "eocs_regs.svh"

module eocs_wb_regs (
  // clock and reset
  input  wire logic                      clk_sys,
  input  wire logic                      reset,
  // bus
  input  wire eocs_pkg::eocs_wb_req_t    wb_req,
  output logic                           wb_ack,
  output logic [31:0]                    wb_dat_o,
  // block side
  input  wire logic [31:0]               status_word,
  input  wire logic [`EOCS_EV_W-1:0]     events,
  output logic                           pol_high,
  output logic                           opt_level,
  output logic                           cmd_on,
  output logic                           cmd_off,
  output logic                           irq
);

  logic [`EOCS_EV_W-1:0] irq_stat;
  logic [`EOCS_EV_W-1:0] irq_mask;
  logic                  req;
  logic                  wr;
  logic                  rd_stat;

  assign req     = wb_req.cyc && wb_req.stb && !wb_ack;
  assign wr      = req && wb_req.we && wb_req.sel[0];
  assign rd_stat = req && !wb_req.we && (wb_req.adr == `EOCS_OFS_IRQ_STAT);

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      wb_ack <= 1'b0;
    end else begin
      wb_ack <= req;
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      wb_dat_o <= 32'h0000_0000;
    end else if (req && !wb_req.we) begin
      case (wb_req.adr)
        `EOCS_OFS_CTRL:     wb_dat_o <= {30'h0, opt_level, pol_high};
        `EOCS_OFS_STATUS:   wb_dat_o <= status_word;
        `EOCS_OFS_IRQ_STAT: wb_dat_o <= {28'h0, irq_stat};
        `EOCS_OFS_IRQ_MASK: wb_dat_o <= {28'h0, irq_mask};
        default:            wb_dat_o <= 32'h0000_0000;
      endcase
    end
  end

  // opt_level only moves on a bus write: no panel path reaches it
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      pol_high  <= 1'(`EOCS_CTRL_RESET >> `EOCS_CTRL_POL_BIT);
      opt_level <= 1'b0;
    end else if (wr && wb_req.adr == `EOCS_OFS_CTRL) begin
      pol_high  <= wb_req.dat[`EOCS_CTRL_POL_BIT];
      opt_level <= wb_req.dat[`EOCS_CTRL_OPT_BIT];
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      cmd_on  <= 1'b0;
      cmd_off <= 1'b0;
    end else begin
      cmd_on  <= wr && wb_req.adr == `EOCS_OFS_CMD && wb_req.dat[`EOCS_CMD_ON_BIT];
      cmd_off <= wr && wb_req.adr == `EOCS_OFS_CMD && wb_req.dat[`EOCS_CMD_OFF_BIT];
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      irq_mask <= `EOCS_MASK_RESET;
    end else if (wr && wb_req.adr == `EOCS_OFS_IRQ_MASK) begin
      irq_mask <= wb_req.dat[`EOCS_EV_W-1:0];
    end
  end

  // a new event wins over the clear-on-read in the same cycle
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      irq_stat <= '0;
    end else if (rd_stat) begin
      irq_stat <= events;
    end else begin
      irq_stat <= irq_stat | events;
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_stat & irq_mask);
    end
  end

endmodule : eocs_wb_regs

// ==== tb/eocs_contact_model.sv ====
// Purpose: contacts with pull-up on the on/off and shutdown pins
// Assumes: bench changes contacts just after an edge
// Notes:   each change chatters two cycles, shorter than the filter
module eocs_contact_model (
  // clock
  input wire logic clk_sys,
  // contacts, high means made
  input wire logic onoff_made,
  input wire logic shut_made,
  // pins
  output logic     ext_onoff_pin,
  output logic     shutdown_n_pin
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] chat_on = 2'h0;
  logic [1:0] chat_sd = 2'h0;
  logic       last_on = 1'h0;
  logic       last_sd = 1'h0;
  initial begin
    ext_onoff_pin  = 1'h1;
    shutdown_n_pin = 1'h1;
  end
  // an open contact floats up to the pull-up, releasing the pin high
  always @(posedge clk_sys) begin
    last_on        <= onoff_made;
    last_sd        <= shut_made;
    chat_on        <= (onoff_made != last_on) ? 2'h2 : chat_on - {1'h0, chat_on != 2'h0};
    chat_sd        <= (shut_made != last_sd) ? 2'h2 : chat_sd - {1'h0, chat_sd != 2'h0};
    ext_onoff_pin  <= (chat_on != 2'h0) ? !ext_onoff_pin : !onoff_made;
    shutdown_n_pin <= (chat_sd != 2'h0) ? !shutdown_n_pin : !shut_made;
  end
endmodule : eocs_contact_model

// ==== tb/eocs_properties.sv ====
// Purpose: timing checks on the ports of eocs_top
// Assumes: one clock, async reset
// Notes:   bound into every eocs_top
module eocs_properties #(
  parameter int DEB_CYC = 4
) (
  // clock and reset
  input wire logic                   clk_sys,
  input wire logic                   reset,
  // ports watched
  input wire eocs_pkg::eocs_wb_req_t wb_req,
  input wire logic                   wb_ack,
  input wire logic                   shutdown_n_pin,
  input wire eocs_pkg::eocs_plant_t  plant,
  input wire logic                   output_enable,
  input wire logic                   breaker_trip,
  input wire eocs_pkg::eocs_status_t status
);
  timeunit 1ns;
  timeprecision 1ps;
  logic       last_sd;
  logic [4:0] sd_stable;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);
  // edges since the shutdown pin last moved, saturating so it never wraps
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      last_sd   <= 1'h1;
      sd_stable <= 5'h00;
    end else begin
      last_sd   <= shutdown_n_pin;
      sd_stable <= (shutdown_n_pin != last_sd) ? 5'h00 : sd_stable + {4'h0, sd_stable != 5'h1F};
    end
  end
  a_ack_next: assert property (wb_req.cyc && wb_req.stb && !wb_ack |=> wb_ack)
    else $error("no ack after request");
  a_ack_single: assert property (wb_ack |=> !wb_ack)
    else $error("ack longer than one cycle");
  a_volt_flag: assert property (!$past(reset) |->
    status.const_voltage_flag == $past(plant.voltage_regulation_mode))
    else $error("voltage mode flag wrong");
  a_curr_flag: assert property (!$past(reset) |->
    status.const_current_flag == $past(plant.current_regulation_mode))
    else $error("current mode flag wrong");
  a_alarm_flag: assert property (!$past(reset) |-> status.alarm_flag ==
    $past(plant.overvoltage_protect | plant.overcurrent_protect | plant.overtemp_protect))
    else $error("alarm flag wrong");
  a_on_flag: assert property (!$past(reset) |-> status.output_on_flag == $past(output_enable))
    else $error("output on flag wrong");
  a_trip_level: assert property (sd_stable == DEB_CYC + 4 |-> breaker_trip == !shutdown_n_pin)
    else $error("trip does not follow settled pin");
  a_trip_filtered: assert property ($rose(breaker_trip) |-> !$past(shutdown_n_pin, 4))
    else $error("trip without settled low pin");
  a_trip_forces_off: assert property (breaker_trip |=> !output_enable)
    else $error("output on while tripped");
  a_option_cause: assert property ($changed(status.option_flag) |->
    $past(wb_ack) || $past(wb_ack, 2) || $past(wb_ack, 3))
    else $error("option changed without bus write");
endmodule : eocs_properties

bind eocs_top eocs_properties #(.DEB_CYC(DEB_CYC)) u_prop (.clk_sys, .reset, .wb_req,
  .wb_ack, .shutdown_n_pin, .plant, .output_enable, .breaker_trip, .status);

// ==== tb/ext_output_control_status_tb.sv ====
// Purpose: self-checking bench of eocs_top
// Assumes: DEB_CYC of 4 keeps the filter short
// Notes:   contacts come from eocs_contact_model
module ext_output_control_status_tb;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {logic [4:0] pl; logic [2:0] ex;} eocs_row_t;
  logic                   clk_sys = 1'h0;
  logic                   reset = 1'h1;
  eocs_pkg::eocs_wb_req_t wb_req = '0;
  eocs_pkg::eocs_plant_t  plant = '0;
  eocs_pkg::eocs_status_t status;
  logic [31:0]            wb_dat_o;
  logic                   wb_ack, irq, output_enable, breaker_trip, ext_onoff_pin, shutdown_n_pin;
  logic                   panel_key_press = 1'h0;
  logic                   onoff_made = 1'h0;
  logic                   shut_made = 1'h0;
  int                     error_cnt = 0;
  int                     num_checks = 0;
  int                     cycles = 0;
  eocs_row_t              rows [6] = '{'{5'h10, 3'h4}, '{5'h08, 3'h2}, '{5'h04, 3'h1},
                                       '{5'h02, 3'h1}, '{5'h01, 3'h1}, '{5'h00, 3'h0}};
  eocs_top #(.DEB_CYC(4)) uut (.clk_sys, .reset, .wb_req, .wb_ack, .wb_dat_o, .irq,
    .ext_onoff_pin, .shutdown_n_pin, .panel_key_press, .plant, .output_enable,
    .breaker_trip, .status);
  eocs_contact_model u_contact (.clk_sys, .onoff_made, .shut_made, .ext_onoff_pin,
    .shutdown_n_pin);
  initial begin
    forever #4 clk_sys = ~clk_sys;
  end
  task automatic stop_test();
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : stop_test
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
  endtask : tick
  task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat,
                    output logic [31:0] rd);
    // no cycle limit here: only the bench timeout ends a wait
    wb_req <= {1'h1, 1'h1, we, adr, 4'hF, dat};
    do begin
      @(posedge clk_sys);
    end while (wb_ack !== 1'h1);
    rd = wb_dat_o;
    wb_req <= '0;
    @(posedge clk_sys);
  endtask : wb
  task automatic key();
    panel_key_press <= 1'h1;
    tick(1);
    panel_key_press <= 1'h0;
    tick(4);
  endtask : key
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 20000) begin
      error_cnt++;
      stop_test();
    end
  end
  initial begin
    logic [31:0] rd;
    tick(4);
    reset <= 1'h0;
    check({output_enable, breaker_trip, irq, status}, 8'h00);
    wb(1'h0, 8'h00, 32'h0, rd);
    check(rd, 32'h1);
    wb(1'h0, 8'h10, 32'h0, rd);
    check(rd, 32'h0);
    wb(1'h0, 8'h14, 32'h0, rd);
    check(rd, 32'h0);
    foreach (rows[i]) begin
      plant <= rows[i].pl;
      tick(2);
      check({status[4:3], status[1]}, rows[i].ex);
    end
    // external input low: key and remote on are both refused
    wb(1'h1, 8'h10, 32'h1, rd);
    onoff_made <= 1'h1;
    tick(16);
    check(output_enable, 1'h0);
    key();
    wb(1'h1, 8'h04, 32'h1, rd);
    tick(3);
    check({output_enable, irq}, 2'h0);
    wb(1'h0, 8'h08, 32'h0, rd);
    check(rd, 32'h10);
    onoff_made <= 1'h0;
    tick(16);
    check({output_enable, status.output_on_flag, irq}, 3'h7);
    wb(1'h0, 8'h0C, 32'h0, rd);
    check(rd[0], 1'h1);
    tick(2);
    check(irq, 1'h0);
    key();
    check({output_enable, status.output_on_flag, irq}, 3'h0);
    // remote on and off with the external input released
    wb(1'h1, 8'h04, 32'h1, rd);
    tick(2);
    check(output_enable, 1'h1);
    wb(1'h1, 8'h04, 32'h2, rd);
    tick(2);
    check(output_enable, 1'h0);
    // option follows only the bus write, not the key
    wb(1'h1, 8'h00, 32'h3, rd);
    tick(3);
    check(status.option_flag, 1'h1);
    key();
    check({output_enable, status.option_flag}, 2'h3);
    shut_made <= 1'h1;
    tick(16);
    check({breaker_trip, output_enable}, 2'h2);
    wb(1'h0, 8'h08, 32'h0, rd);
    check(rd, 32'h60);
    shut_made <= 1'h0;
    tick(16);
    check(breaker_trip, 1'h0);
    // inverted polarity: open contact holds off, closing turns on
    wb(1'h1, 8'h00, 32'h0, rd);
    tick(16);
    key();
    check(output_enable, 1'h0);
    onoff_made <= 1'h1;
    tick(16);
    check(output_enable, 1'h1);
    reset <= 1'h1;
    tick(2);
    check({output_enable, status}, 6'h00);
    reset <= 1'h0;
    wb(1'h0, 8'h00, 32'h0, rd);
    check(rd, 32'h1);
    stop_test();
  end
endmodule : ext_output_control_status_tb
